// File: common/arsc_pkg.sv
package arsc_pkg;

   // range table size and index width
   localparam int          ARSC_RANGE_COUNT = 8;
   localparam int          ARSC_IDX_W       = 3;
   localparam int          ARSC_RNG_W       = 16;
   localparam logic [2:0]  ARSC_IDX_TOP     = 3'h7;
   localparam logic [2:0]  ARSC_IDX_BOTTOM  = 3'h0;

   // voltage ranges in 0.1 V steps: 15 V .. 1000 V at ratio three, 7.5 V .. 500 V at ratio six
   localparam logic [15:0] ARSC_V_RANGE_CF3 [0:7] = '{16'h0096, 16'h012C, 16'h0258, 16'h03E8,
                                                      16'h05DC, 16'h0BB8, 16'h1770, 16'h2710};
   localparam logic [15:0] ARSC_V_RANGE_CF6 [0:7] = '{16'h004B, 16'h0096, 16'h012C, 16'h01F4,
                                                      16'h02EE, 16'h05DC, 16'h0BB8, 16'h1388};
   // current ranges in 0.1 mA steps
   localparam logic [15:0] ARSC_I_RANGE_CF3 [0:7] = '{16'h0064, 16'h00C8, 16'h01F4, 16'h03E8,
                                                      16'h07D0, 16'h1388, 16'h2710, 16'h4E20};
   localparam logic [15:0] ARSC_I_RANGE_CF6 [0:7] = '{16'h0032, 16'h0064, 16'h00FA, 16'h01F4,
                                                      16'h03E8, 16'h09C4, 16'h1388, 16'h2710};

   // percentage thresholds
   localparam logic [9:0]  ARSC_PCT_UNIT    = 10'h064;
   localparam logic [9:0]  ARSC_PCT_RMS_UP  = 10'h06E;
   localparam logic [9:0]  ARSC_PCT_PK_UP3  = 10'h14A;
   localparam logic [9:0]  ARSC_PCT_PK_UP6  = 10'h294;
   localparam logic [9:0]  ARSC_PCT_RMS_DN  = 10'h01E;
   localparam logic [9:0]  ARSC_PCT_PK_DN3  = 10'h12C;
   localparam logic [9:0]  ARSC_PCT_PK_DN6  = 10'h258;

   // peak-ratio setting codes
   localparam logic [3:0]  ARSC_RATIO_THREE = 4'h3;
   localparam logic [3:0]  ARSC_RATIO_SIX   = 4'h6;
   localparam logic [3:0]  ARSC_RATIO_RESET = 4'h3;

   // power range multipliers
   localparam logic [1:0]  ARSC_PMUL_ONE    = 2'h1;
   localparam logic [1:0]  ARSC_PMUL_TWO    = 2'h2;
   localparam logic [1:0]  ARSC_PMUL_THREE  = 2'h3;

   // power scaling coefficient fraction bits and unity
   localparam int          ARSC_SF_FRAC     = 8;
   localparam logic [15:0] ARSC_SF_UNITY    = 16'h0100;

   // line filter cutoff codes
   localparam logic [1:0]  ARSC_CUT_500HZ   = 2'h0;
   localparam logic [1:0]  ARSC_CUT_RESET   = 2'h0;

   typedef enum logic [2:0] {
      ARSC_SINGLE_PHASE_TWO_WIRE         = 3'h0,
      ARSC_SINGLE_PHASE_THREE_WIRE       = 3'h1,
      ARSC_THREE_PHASE_THREE_WIRE        = 3'h2,
      ARSC_THREE_VOLTAGE_THREE_CURRENT   = 3'h3,
      ARSC_THREE_PHASE_FOUR_WIRE         = 3'h4
   } arsc_wiring_e;

   typedef enum logic [1:0] {
      ARSC_ST_FIXED = 2'b01,
      ARSC_ST_AUTO  = 2'b10
   } arsc_state_e;

endpackage

// File: core/arsc_range_ctrl.sv
// Operation
// [R1] ranges are held and compared as rms quantities for voltage and current
// [R2] fixed mode keeps the chosen range whatever the input amplitude does
// [R3] voltage ranges 15 V..1000 V at ratio three, 7.5 V..500 V at six
// [R4] auto mode steps only through the fixed-mode range list
// [R5] step up when rms exceeds 110% of present range
// [R6] ratio three: step up when peak exceeds 330% of present range
// [R7] ratio six: step up when peak exceeds 660% of present range
// [R8] step down when rms <=30% and peak <=300%/600% of next lower range
// [R9] step-down peaks are the values without offset zeroing
// [R10] waveform full scale equals range times peak ratio
// [R11] power range is V*I times 1, 2 or 3 by wiring system
// [R12] external sensor divides current, powers and peak current by mV/A ratio
// [R13] voltage results times VT ratio, current results times CT ratio
// [R14] powers times VT ratio, CT ratio and power scaling coefficient
// [R15] line filter strips high frequencies from V, I, P paths, cutoff selectable
// [R16] frequency filter acts only on frequency and zero-crossing path
// [R17] 500 Hz line cutoff forces the frequency filter on
// [R18] peak ratio accepts only three or six, selects thresholds and range list
// [R19] one decision per update interval, one step, increase before decrease
// [R20] range saturates at top and bottom
`timescale 1ns/1ps
module arsc_range_ctrl #(
   parameter int DW = 24,
   parameter int OW = 32,
   parameter int RW = 16
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          ce_in,
   input  wire logic                          update_in,
   input  wire logic                          auto_range_in,
   input  wire logic [arsc_pkg::ARSC_IDX_W-1:0] fixed_v_idx_in,
   input  wire logic [arsc_pkg::ARSC_IDX_W-1:0] fixed_i_idx_in,
   input  wire logic [3:0]                    peak_ratio_setting_in,
   input  wire logic [2:0]                    wiring_in,
   input  wire logic [DW-1:0]                 urms_in,
   input  wire logic [DW-1:0]                 irms_in,
   input  wire logic [DW-1:0]                 upk_in,
   input  wire logic [DW-1:0]                 ipk_in,
   input  wire logic [DW-1:0]                 upk_raw_in,
   input  wire logic [DW-1:0]                 ipk_raw_in,
   input  wire logic [DW-1:0]                 p_in,
   input  wire logic [DW-1:0]                 s_in,
   input  wire logic [DW-1:0]                 q_in,
   input  wire logic                          sensor_en_in,
   input  wire logic [RW-1:0]                 sensor_ratio_in,
   input  wire logic [RW-1:0]                 vt_ratio_in,
   input  wire logic [RW-1:0]                 ct_ratio_in,
   input  wire logic [RW-1:0]                 power_scaling_coefficient_in,
   input  wire logic                          line_filter_en_in,
   input  wire logic [1:0]                    line_cutoff_in,
   input  wire logic                          freq_filter_en_in,
   output logic [arsc_pkg::ARSC_IDX_W-1:0]    v_idx_out,
   output logic [arsc_pkg::ARSC_IDX_W-1:0]    i_idx_out,
   output logic [arsc_pkg::ARSC_RNG_W-1:0]    v_range_out,
   output logic [arsc_pkg::ARSC_RNG_W-1:0]    i_range_out,
   output logic [33:0]                        power_range_out,
   output logic [19:0]                        v_full_scale_out,
   output logic [19:0]                        i_full_scale_out,
   output logic                               ratio_six_out,
   output logic                               auto_active_out,
   output logic [OW-1:0]                      u_out,
   output logic [OW-1:0]                      i_out,
   output logic [OW-1:0]                      p_out,
   output logic [OW-1:0]                      s_out,
   output logic [OW-1:0]                      q_out,
   output logic [OW-1:0]                      upk_out,
   output logic [OW-1:0]                      ipk_out,
   output logic                               result_valid_out,
   output logic                               line_filter_on_out,
   output logic [1:0]                         line_cutoff_out,
   output logic                               freq_filter_on_out
);
   import arsc_pkg::*;

   // val*100 > rng*pct, both sides widened so nothing wraps
   function automatic logic pct_above(input logic [DW-1:0] val, input logic [15:0] rng,
                                      input logic [9:0] pct);
      logic [47:0] lhs;
      logic [47:0] rhs;
      lhs = 48'({val} * 48'(ARSC_PCT_UNIT));
      rhs = 48'({rng} * 48'(pct));
      return lhs > rhs;
   endfunction

   function automatic logic [15:0] range_of(input logic six, input logic is_i,
                                            input logic [ARSC_IDX_W-1:0] idx);
      logic [15:0] r;
      if (is_i) begin
         r = six ? ARSC_I_RANGE_CF6[idx] : ARSC_I_RANGE_CF3[idx];
      end else begin
         r = six ? ARSC_V_RANGE_CF6[idx] : ARSC_V_RANGE_CF3[idx];
      end
      return r;
   endfunction

   // x * m1 * m2 * m3 / div kept full width so the fraction shift sees every bit; zero divisor as one
   function automatic logic [95:0] scale(input logic [DW-1:0] x, input logic [RW-1:0] m1,
                                         input logic [RW-1:0] m2, input logic [RW-1:0] m3,
                                         input logic [RW-1:0] div);
      logic [95:0] prod;
      logic [95:0] d;
      prod = 96'(x) * 96'(m1) * 96'(m2) * 96'(m3);
      d    = (div == '0) ? 96'h1 : 96'(div);
      return prod / d;
   endfunction

   // next range index for one channel
   function automatic logic [ARSC_IDX_W-1:0] step(input logic [ARSC_IDX_W-1:0] idx, input logic six,
                                                  input logic is_i, input logic [DW-1:0] rms,
                                                  input logic [DW-1:0] pk, input logic [DW-1:0] pk_raw);
      logic [15:0]           cur;
      logic [15:0]           low;
      logic                  up;
      logic                  dn;
      logic [ARSC_IDX_W-1:0] nxt;
      cur = range_of(six, is_i, idx);                                          // R4
      low = range_of(six, is_i, (idx == ARSC_IDX_BOTTOM) ? idx : idx - 3'h1);
      up  = pct_above(rms, cur, ARSC_PCT_RMS_UP)                               // R5 R1
            || pct_above(pk, cur, six ? ARSC_PCT_PK_UP6 : ARSC_PCT_PK_UP3);    // R6 R7
      dn  = !pct_above(rms, cur, ARSC_PCT_RMS_DN)                              // R8
            && !pct_above(pk_raw, low, six ? ARSC_PCT_PK_DN6 : ARSC_PCT_PK_DN3); // R8 R9
      nxt = idx;
      if (up) begin                                                            // R19
         if (idx != ARSC_IDX_TOP) begin                                        // R20
            nxt = idx + 3'h1;
         end
      end else if (dn && idx != ARSC_IDX_BOTTOM) begin                         // R20
         nxt = idx - 3'h1;
      end
      return nxt;
   endfunction

   arsc_state_e           state;
   arsc_state_e           next_state;
   logic [ARSC_IDX_W-1:0] v_idx;
   logic [ARSC_IDX_W-1:0] next_v_idx;
   logic [ARSC_IDX_W-1:0] i_idx;
   logic [ARSC_IDX_W-1:0] next_i_idx;
   logic                  ratio_six;
   logic                  next_ratio_six;

   // range selection group
   always_comb begin
      next_state     = state;
      next_v_idx     = v_idx;
      next_i_idx     = i_idx;
      next_ratio_six = ratio_six;
      // other codes leave the setting as it was
      if (peak_ratio_setting_in == ARSC_RATIO_SIX) begin                       // R18
         next_ratio_six = 1'b1;
      end else if (peak_ratio_setting_in == ARSC_RATIO_THREE) begin            // R18
         next_ratio_six = 1'b0;
      end
      unique case (state)
         ARSC_ST_FIXED: begin
            next_v_idx = fixed_v_idx_in;                                       // R2 R3
            next_i_idx = fixed_i_idx_in;                                       // R2
            if (auto_range_in) begin
               next_state = ARSC_ST_AUTO;
            end
         end
         ARSC_ST_AUTO: begin
            if (!auto_range_in) begin
               next_state = ARSC_ST_FIXED;
            end else if (update_in) begin                                      // R19
               next_v_idx = step(v_idx, ratio_six, 1'b0, urms_in, upk_in, upk_raw_in);
               next_i_idx = step(i_idx, ratio_six, 1'b1, irms_in, ipk_in, ipk_raw_in);
            end
         end
         default: begin
            next_state = ARSC_ST_FIXED;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state     <= ARSC_ST_FIXED;
         v_idx     <= ARSC_IDX_BOTTOM;
         i_idx     <= ARSC_IDX_BOTTOM;
         ratio_six <= 1'b0;
      end else if (ce_in) begin
         state     <= next_state;
         v_idx     <= next_v_idx;
         i_idx     <= next_i_idx;
         ratio_six <= next_ratio_six;
      end
   end

   // derived range outputs group
   logic [15:0] next_v_range;
   logic [15:0] next_i_range;
   logic [33:0] next_power_range;
   logic [19:0] next_v_full;
   logic [19:0] next_i_full;
   logic [1:0]  pmul;

   always_comb begin
      next_v_range = range_of(ratio_six, 1'b0, v_idx);                         // R1 R3
      next_i_range = range_of(ratio_six, 1'b1, i_idx);
      unique case (wiring_in)
         ARSC_SINGLE_PHASE_TWO_WIRE: pmul = ARSC_PMUL_ONE;                     // R11
         ARSC_SINGLE_PHASE_THREE_WIRE, ARSC_THREE_PHASE_THREE_WIRE,
         ARSC_THREE_VOLTAGE_THREE_CURRENT: pmul = ARSC_PMUL_TWO;               // R11
         ARSC_THREE_PHASE_FOUR_WIRE: pmul = ARSC_PMUL_THREE;                   // R11
         default: pmul = ARSC_PMUL_ONE;
      endcase
      next_power_range = 34'(next_v_range) * 34'(next_i_range) * 34'(pmul);
      // display span is range times 3 or 6
      next_v_full = ratio_six ? 20'(next_v_range) * 20'h0_0006 : 20'(next_v_range) * 20'h0_0003; // R10
      next_i_full = ratio_six ? 20'(next_i_range) * 20'h0_0006 : 20'(next_i_range) * 20'h0_0003; // R10
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         v_idx_out        <= ARSC_IDX_BOTTOM;
         i_idx_out        <= ARSC_IDX_BOTTOM;
         v_range_out      <= '0;
         i_range_out      <= '0;
         power_range_out  <= '0;
         v_full_scale_out <= '0;
         i_full_scale_out <= '0;
         ratio_six_out    <= 1'b0;
         auto_active_out  <= 1'b0;
      end else if (ce_in) begin
         v_idx_out        <= v_idx;
         i_idx_out        <= i_idx;
         v_range_out      <= next_v_range;
         i_range_out      <= next_i_range;
         power_range_out  <= next_power_range;
         v_full_scale_out <= next_v_full;
         i_full_scale_out <= next_i_full;
         ratio_six_out    <= ratio_six;
         auto_active_out  <= (state == ARSC_ST_AUTO);
      end
   end

   // scaled results group, latched once per update interval
   logic [RW-1:0] div;
   logic [RW-1:0] unity;
   logic [RW-1:0] sf_int;
   logic [OW-1:0] next_u;
   logic [OW-1:0] next_i;
   logic [OW-1:0] next_p;
   logic [OW-1:0] next_s;
   logic [OW-1:0] next_q;
   logic [OW-1:0] next_upk;
   logic [OW-1:0] next_ipk;

   always_comb begin
      unity    = RW'(1);
      // coefficient carries eight fraction bits; drop them after the product
      sf_int   = power_scaling_coefficient_in;
      div      = sensor_en_in ? sensor_ratio_in : unity;                       // R12
      next_u   = OW'(scale(urms_in, vt_ratio_in, unity, unity, unity));        // R13
      next_upk = OW'(scale(upk_in, vt_ratio_in, unity, unity, unity));         // R13
      next_i   = OW'(scale(irms_in, ct_ratio_in, unity, unity, div));          // R12 R13
      next_ipk = OW'(scale(ipk_in, ct_ratio_in, unity, unity, div));           // R12 R13
      next_p   = OW'(scale(p_in, vt_ratio_in, ct_ratio_in, sf_int, div) >> ARSC_SF_FRAC); // R14 R12
      next_s   = OW'(scale(s_in, vt_ratio_in, ct_ratio_in, sf_int, div) >> ARSC_SF_FRAC); // R14 R12
      next_q   = OW'(scale(q_in, vt_ratio_in, ct_ratio_in, sf_int, div) >> ARSC_SF_FRAC); // R14 R12
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         u_out            <= '0;
         i_out            <= '0;
         p_out            <= '0;
         s_out            <= '0;
         q_out            <= '0;
         upk_out          <= '0;
         ipk_out          <= '0;
         result_valid_out <= 1'b0;
      end else if (ce_in) begin
         result_valid_out <= update_in;
         if (update_in) begin
            u_out   <= next_u;
            i_out   <= next_i;
            p_out   <= next_p;
            s_out   <= next_s;
            q_out   <= next_q;
            upk_out <= next_upk;
            ipk_out <= next_ipk;
         end
      end
   end

   // filter selection group; the filters themselves sit in the analog path
   logic next_freq_on;

   always_comb begin
      next_freq_on = freq_filter_en_in                                         // R16
                     || (line_filter_en_in && line_cutoff_in == ARSC_CUT_500HZ); // R17
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         line_filter_on_out <= 1'b0;
         line_cutoff_out    <= ARSC_CUT_RESET;
         freq_filter_on_out <= 1'b0;
      end else if (ce_in) begin
         line_filter_on_out <= line_filter_en_in;                              // R15
         line_cutoff_out    <= line_cutoff_in;                                 // R15
         freq_filter_on_out <= next_freq_on;
      end
   end

endmodule

// File: bench/arsc_front_model.sv
`timescale 1ns/1ps
module arsc_front_model #(
   parameter int DW = 24
) (
   input  wire logic          clk_in,
   input  wire logic          pulse_in,
   input  wire logic [DW-1:0] v_rms_in,
   input  wire logic [DW-1:0] v_pk_in,
   input  wire logic [DW-1:0] i_rms_in,
   input  wire logic [DW-1:0] i_pk_in,
   input  wire logic [DW-1:0] off_in,
   output logic              update_out = 1'b0,
   output logic [DW-1:0]     urms_out = '0,
   output logic [DW-1:0]     irms_out = '0,
   output logic [DW-1:0]     upk_out = '0,
   output logic [DW-1:0]     ipk_out = '0,
   output logic [DW-1:0]     upk_raw_out = '0,
   output logic [DW-1:0]     ipk_raw_out = '0
);
   // zeroed peaks lose the offset, raw peaks keep it, so the two can disagree
   always @(negedge clk_in) begin
      update_out  <= pulse_in;
      urms_out    <= v_rms_in;
      irms_out    <= i_rms_in;
      upk_raw_out <= v_pk_in;
      ipk_raw_out <= i_pk_in;
      upk_out     <= (v_pk_in > off_in) ? v_pk_in - off_in : '0;
      ipk_out     <= (i_pk_in > off_in) ? i_pk_in - off_in : '0;
   end
endmodule

// File: bench/arsc_range_ctrl_assertions.sv
`timescale 1ns/1ps
module arsc_range_checker #(
   parameter int DW = 24,
   parameter int OW = 32,
   parameter int RW = 16
) (
   input wire logic                            clk_in,
   input wire logic                            rst_b_in,
   input wire logic                            ce_in,
   input wire logic                            update_in,
   input wire logic                            auto_range_in,
   input wire logic [arsc_pkg::ARSC_IDX_W-1:0] fixed_v_idx_in,
   input wire logic [2:0]                      wiring_in,
   input wire logic [DW-1:0]                   irms_in,
   input wire logic [DW-1:0]                   p_in,
   input wire logic                            sensor_en_in,
   input wire logic [RW-1:0]                   sensor_ratio_in,
   input wire logic [RW-1:0]                   vt_ratio_in,
   input wire logic [RW-1:0]                   ct_ratio_in,
   input wire logic [RW-1:0]                   power_scaling_coefficient_in,
   input wire logic                            line_filter_en_in,
   input wire logic [1:0]                      line_cutoff_in,
   input wire logic                            freq_filter_en_in,
   input wire logic [arsc_pkg::ARSC_IDX_W-1:0] v_idx_out,
   input wire logic [arsc_pkg::ARSC_RNG_W-1:0] v_range_out,
   input wire logic [arsc_pkg::ARSC_RNG_W-1:0] i_range_out,
   input wire logic [33:0]                     power_range_out,
   input wire logic [19:0]                     v_full_scale_out,
   input wire logic                            ratio_six_out,
   input wire logic [OW-1:0]                   i_out,
   input wire logic [OW-1:0]                   p_out,
   input wire logic                            result_valid_out,
   input wire logic                            freq_filter_on_out
);
   import arsc_pkg::*;
   logic [1:0] age;
   logic [1:0] next_age;
   logic       rdy;
   // outputs still hold reset zeros for the first edges after release
   always_comb begin
      next_age = (age == 2'h3) ? age : age + 2'h1;
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) age <= 2'h0;
      else age <= next_age;
   end
   assign rdy = (age == 2'h3);
   function automatic logic [33:0] pmul(input logic [2:0] w);
      pmul = (w == 3'h0 || w > 3'h4) ? 34'(ARSC_PMUL_ONE) : (w == 3'h4) ? 34'(ARSC_PMUL_THREE) : 34'(ARSC_PMUL_TWO);
   endfunction
   function automatic logic [79:0] dv(input logic en, input logic [RW-1:0] r);
      dv = (en && r != '0) ? 80'(r) : 80'h1;
   endfunction
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   a_fixed_holds_idx: assert property ((!auto_range_in && ce_in)[*4] ##1 1'b1 |-> v_idx_out == $past(fixed_v_idx_in, 2))
      else $error("fixed range index not followed");
   a_range_from_table: assert property (rdy && $stable(ratio_six_out) && $stable(v_idx_out) |->
      v_range_out == (ratio_six_out ? ARSC_V_RANGE_CF6[v_idx_out] : ARSC_V_RANGE_CF3[v_idx_out]))
      else $error("voltage range not from list");
   a_power_range_mult: assert property (rdy && $stable(v_range_out) && $stable(i_range_out) && $stable(wiring_in)
      && $past(wiring_in, 2) == wiring_in && $past(wiring_in, 3) == wiring_in
      |-> power_range_out == 34'(v_range_out) * 34'(i_range_out) * pmul(wiring_in)) else $error("power range wrong");
   a_full_scale_span: assert property (rdy && $stable(v_range_out) && $stable(ratio_six_out) |->
      v_full_scale_out == 20'(v_range_out) * (ratio_six_out ? 20'h0_0006 : 20'h0_0003)) else $error("full scale wrong");
   a_valid_one_pulse: assert property (rdy && $past(ce_in) |-> result_valid_out == $past(update_in && ce_in))
      else $error("result valid pulse wrong");
   a_current_scaled: assert property (update_in && ce_in |=>
      i_out == OW'((80'($past(irms_in)) * $past(ct_ratio_in)) / dv($past(sensor_en_in), $past(sensor_ratio_in))))
      else $error("current result scaling wrong");
   a_power_scaled: assert property (update_in && ce_in |=> p_out == OW'(((80'($past(p_in)) * $past(vt_ratio_in)
      * $past(ct_ratio_in) * $past(power_scaling_coefficient_in)) / dv($past(sensor_en_in), $past(sensor_ratio_in)))
      >> ARSC_SF_FRAC)) else $error("power result scaling wrong");
   a_freq_filter_forced: assert property (rdy && $past(ce_in) |-> freq_filter_on_out ==
      $past(freq_filter_en_in || (line_filter_en_in && line_cutoff_in == ARSC_CUT_500HZ)))
      else $error("frequency filter enable wrong");
   c_step_up: cover property (rdy && v_idx_out == $past(v_idx_out) + 3'h1);
   c_six_top: cover property (ratio_six_out && v_idx_out == ARSC_IDX_TOP);
   c_sensor_update: cover property (update_in && sensor_en_in);
endmodule
bind arsc_range_ctrl arsc_range_checker #(.DW(DW), .OW(OW), .RW(RW)) arsc_range_checker_i (.*);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import arsc_pkg::*;
   logic        clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, auto_range_in = 1'b0, sensor_en_in = 1'b0;
   logic        line_filter_en_in = 1'b0, freq_filter_en_in = 1'b0, pulse = 1'b0, update_in;
   logic [2:0]  fixed_v_idx_in = 3'h0, fixed_i_idx_in = 3'h0, wiring_in = 3'h0, v_idx_out, i_idx_out;
   logic [3:0]  peak_ratio_setting_in = 4'h3;
   logic [1:0]  line_cutoff_in = 2'h0, line_cutoff_out;
   logic [15:0] sensor_ratio_in = 16'h0001, vt_ratio_in = 16'h0001, ct_ratio_in = 16'h0001;
   logic [15:0] power_scaling_coefficient_in = ARSC_SF_UNITY, v_range_out, i_range_out;
   logic [23:0] urms_in, irms_in, upk_in, ipk_in, upk_raw_in, ipk_raw_in, s_in, q_in, p_in = 24'h00_0000;
   logic [23:0] v_rms = 24'h00_0000, v_pk = 24'h00_0000, off = 24'h00_0000, i_rms = 24'h00_0000, i_pk = 24'h00_0000;
   logic [33:0] power_range_out;
   logic [19:0] v_full_scale_out, i_full_scale_out;
   logic [31:0] u_out, i_out, p_out, s_out, q_out, upk_out, ipk_out;
   logic        ratio_six_out, auto_active_out, result_valid_out, line_filter_on_out, freq_filter_on_out;
   int          miscompares = 0, comparisons = 0;
   assign s_in = p_in;
   assign q_in = p_in;
   arsc_range_ctrl arsc_range_ctrl_i (.*);
   arsc_front_model arsc_front_model_i (.clk_in(clk_in), .pulse_in(pulse), .v_rms_in(v_rms), .v_pk_in(v_pk),
      .i_rms_in(i_rms), .i_pk_in(i_pk), .off_in(off), .update_out(update_in), .urms_out(urms_in), .irms_out(irms_in),
      .upk_out(upk_in), .ipk_out(ipk_in), .upk_raw_out(upk_raw_in), .ipk_raw_out(ipk_raw_in));
   initial forever #12.5 clk_in = ~clk_in;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic sv(input logic [23:0] r, input logic [23:0] pk, input logic [23:0] o, input logic [2:0] e);
      @(negedge clk_in);
      v_rms <= r;
      v_pk <= pk;
      off <= o;
      @(negedge clk_in) pulse <= 1'b1;
      @(negedge clk_in) pulse <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk(v_idx_out, e);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      logic [15:0] ev, ei;
      int          r;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in) rst_b_in <= 1'b1;
      for (int n = 0; n < 16; n++) begin
         r = (n < 8) ? 3 : 6;
         @(negedge clk_in);
         peak_ratio_setting_in <= 4'(r);
         fixed_v_idx_in <= 3'(n);
         fixed_i_idx_in <= 3'(7 - n);
         wiring_in <= 3'(n % 5);
         sv(24'hFF_FFFF, 24'h00_0000, 24'h00_0000, 3'(n));
         ev = (r == 6) ? ARSC_V_RANGE_CF6[n % 8] : ARSC_V_RANGE_CF3[n % 8];
         ei = (r == 6) ? ARSC_I_RANGE_CF6[7 - n % 8] : ARSC_I_RANGE_CF3[7 - n % 8];
         chk(v_range_out, ev);
         chk(auto_active_out, 1'b0);
         chk(i_range_out, ei);
         chk(ratio_six_out, r == 6);
         chk(v_full_scale_out, 20'(ev) * 20'(r));
         chk(i_full_scale_out, 20'(ei) * 20'(r));
         chk(power_range_out, 34'(ev) * 34'(ei) * ((n % 5 == 0) ? 34'h1 : (n % 5 == 4) ? 34'h3 : 34'h2));
         if (n % 8 == 0) chk(v_range_out, (r == 6) ? 16'h004B : 16'h0096);
         if (n % 8 == 7) chk(v_range_out, (r == 6) ? 16'h1388 : 16'h2710);
      end
      @(negedge clk_in) peak_ratio_setting_in <= 4'h4;
      repeat (3) @(negedge clk_in);
      chk(ratio_six_out, 1'b1);
      $display("test fixed ranges done");
      peak_ratio_setting_in <= 4'h3;
      fixed_v_idx_in <= 3'h0;
      fixed_i_idx_in <= 3'h0;
      repeat (4) @(negedge clk_in);
      auto_range_in <= 1'b1;
      sv(24'h00_00A5, 24'h00_0000, 24'h00_0000, 3'h0);
      sv(24'h00_00A6, 24'h00_0000, 24'h00_0000, 3'h1);
      chk(auto_active_out, 1'b1);
      sv(24'h00_0000, 24'h10_03DE, 24'h10_0000, 3'h1);
      sv(24'h00_0000, 24'h10_03DF, 24'h10_0000, 3'h2);
      for (int k = 3; k < 9; k++) sv(24'hFF_FFFF, 24'h00_0000, 24'h00_0000, (k > 7) ? 3'h7 : 3'(k));
      chk(i_idx_out, 3'h0);
      sv(24'h00_0BB9, 24'h00_4650, 24'h00_0000, 3'h7);
      sv(24'h00_0BB8, 24'h00_4651, 24'h00_0000, 3'h7);
      sv(24'h00_0BB8, 24'h00_4650, 24'h00_0000, 3'h6);
      sv(24'h00_0708, 24'h00_2329, 24'h00_03E8, 3'h6);
      sv(24'h00_0708, 24'h00_2328, 24'h00_03E8, 3'h5);
      ce_in <= 1'b0;
      sv(24'hFF_FFFF, 24'h00_0000, 24'h00_0000, 3'h5);
      ce_in <= 1'b1;
      @(negedge clk_in) peak_ratio_setting_in <= 4'h6;
      sv(24'h00_0000, 24'h00_26AC, 24'h00_0000, 3'h5);
      sv(24'h00_0000, 24'h00_26AD, 24'h00_0000, 3'h6);
      chk(v_range_out, ARSC_V_RANGE_CF6[6]);
      for (int k = 5; k >= -1; k--) sv(24'h00_0000, 24'h00_0000, 24'h00_0000, (k < 0) ? 3'h0 : 3'(k));
      $display("test auto range done");
      @(negedge clk_in);
      auto_range_in <= 1'b0;
      vt_ratio_in <= 16'h0003;
      ct_ratio_in <= 16'h0005;
      power_scaling_coefficient_in <= 16'h0200;
      i_rms <= 24'h00_0028;
      i_pk <= 24'h00_000A;
      p_in <= 24'h40_0000;
      sv(24'h00_0064, 24'h00_0014, 24'h00_0000, 3'h0);
      chk(u_out, 32'h0000_012C);
      chk(upk_out, 32'h0000_003C);
      chk(i_out, 32'h0000_00C8);
      chk(ipk_out, 32'h0000_0032);
      chk(p_out, 32'h0780_0000);
      chk(q_out, 32'h0780_0000);
      @(negedge clk_in);
      sensor_en_in <= 1'b1;
      sensor_ratio_in <= 16'h0005;
      sv(24'h00_0064, 24'h00_0014, 24'h00_0000, 3'h0);
      chk(i_out, 32'h0000_0028);
      chk(ipk_out, 32'h0000_000A);
      chk(s_out, 32'h0180_0000);
      $display("test scaling done");
      for (int n = 0; n < 8; n++) begin
         @(negedge clk_in);
         line_filter_en_in <= n[0];
         line_cutoff_in <= {1'b0, n[1]};
         freq_filter_en_in <= n[2];
         repeat (3) @(negedge clk_in);
         chk(freq_filter_on_out, n[2] | (n[0] & !n[1]));
         chk(line_filter_on_out, n[0]);
         chk(line_cutoff_out, {1'b0, n[1]});
      end
      $display("test filters done");
      tally_and_finish;
   end
endmodule
